// ==== src/tssm_pkg.sv ====
// Constants for the two-speed start-up and fail-safe clock monitor.
// Assumes all inputs are synchronous to sys_clk except the oscillator levels,
// which are sampled through two-flop synchronisers inside the monitor.
// Summary of operation
// - Crystal modes count 1024 external oscillations first.
// - Two-speed disabled outside the three crystal modes.
// - Count done before sleep sets status, switches.
// - Sleep aborts start-up count, status stays clear.
// - Two-speed needs enable, select 00, crystal mode.
// - Two-speed begins after reset/power-up and wake-up.
// - Count, internal fall, flag, hold low, switch.
// - Monitor enable bit; supervises every external mode.
// - Monitor detects only after start-up timer expires.
// - Sample clock is low-frequency oscillator divided by 64.
// - External fall sets latch, sample rise clears.
// - Failure when a whole sample period lacks external fall.
// - Failure switches to internal, sets fail flag.
// - Interrupt when fail flag and its enable set.
// - Frequency select chooses fallback internal clock.
// - Stay internal until firmware restarts and switches.
// - Reset, sleep or select change clears fail-safe.
// - Select change restarts timer; timeout clears fail-safe (code clears it at the select change itself).
// - Fail flag clear ignored while fail-safe active.
// - Timer skipped in external clock and RC modes.
// - Monitor enable also enables two-speed start-up.
// - Select 00 primary, 01 timer osc, 1x internal.
package tssm_pkg;
    typedef enum logic [2:0] {
        TSSM_MODE_LP,
        TSSM_MODE_XT,
        TSSM_MODE_HS,
        TSSM_MODE_EC,
        TSSM_MODE_RC,
        TSSM_MODE_INT
    } tssm_mode_t;

    typedef enum logic [1:0] {
        TSSM_SRC_PRIMARY,
        TSSM_SRC_TIMER_OSC,
        TSSM_SRC_INTERNAL,
        TSSM_SRC_HOLD
    } tssm_src_t;

    localparam logic [1:0]  TSSM_SCS_PRIMARY   = 2'h0;
    localparam logic [1:0]  TSSM_SCS_TIMER_OSC = 2'h1;
    localparam int          TSSM_SCS_INT_BIT   = 1;
    localparam logic [3:0]  TSSM_INTERNAL_FREQ_SELECT_RESET    = 4'h7;
    localparam logic [10:0] TSSM_OST_COUNT     = 11'h400;
    localparam logic [5:0]  TSSM_SAMPLE_DIV    = 6'h3f;
endpackage

// ==== src/tssm_monitor.sv ====
// Clock start-up sequencer and fail-safe monitor.
// Assumes oscillator inputs are slow level signals oversampled by sys_clk;
// control bits come from configuration words and software registers.
`timescale 1ns/1ps
module tssm_monitor
    import tssm_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       ext_osc,
    input  wire logic       low_freq_internal_osc,
    input  wire tssm_mode_t primary_osc_mode,
    input  wire logic       two_speed_enable,
    input  wire logic       fail_monitor_enable,
    input  wire logic       powerup_timer_done,
    input  wire logic [1:0] clock_source_select,
    input  wire logic [3:0] internal_freq_select,
    input  wire logic       sleep_exec,
    input  wire logic       wake_up,
    input  wire logic       timer_osc_enable,
    input  wire logic       timer_osc_stable,
    input  wire logic       osc_fail_flag_clear,
    input  wire logic       osc_fail_irq_enable,
    output tssm_src_t       clock_mux_select,
    output logic [3:0]      internal_freq_out,
    output logic            clock_hold_low,
    output logic            startup_timeout_status,
    output logic            timer_osc_ready_flag,
    output logic            osc_fail_flag,
    output logic            fail_safe_active,
    output logic            osc_fail_irq
);
    typedef enum logic [2:0] {
        TSSM_ST_WAIT_POWERUP_TIMER,
        TSSM_ST_COUNT,
        TSSM_ST_INT_FALL,
        TSSM_ST_HOLD,
        TSSM_ST_RUN,
        TSSM_ST_SLEEP
    } tssm_state_t;

    tssm_state_t state;
    logic [10:0] ost_cnt;
    logic [1:0]  ext_sync;
    logic        ext_prev;
    logic [1:0]  lf_sync;
    logic        lf_prev;
    logic [5:0]  div_cnt;
    logic        sample_clk;
    logic        sample_prev;
    logic        det_latch;
    logic        det_sync1;
    logic        det_sync2;
    logic [1:0]  scs_prev;
    logic        failed;

    wire logic is_crystal = (primary_osc_mode == TSSM_MODE_LP) ||
                            (primary_osc_mode == TSSM_MODE_XT) ||
                            (primary_osc_mode == TSSM_MODE_HS);
    wire logic ext_fall = ext_prev & ~ext_sync[1];
    wire logic lf_rise = lf_sync[1] & ~lf_prev;
    wire logic int_fall = lf_prev & ~lf_sync[1];
    wire logic sample_rise = sample_clk & ~sample_prev;
    wire logic scs_changed = clock_source_select != scs_prev;
    // Monitor enable forces two-speed on as well
    wire logic two_speed_on = (two_speed_enable | fail_monitor_enable) &&
                              (clock_source_select == TSSM_SCS_PRIMARY) &&
                              is_crystal;
    wire logic monitored = fail_monitor_enable && primary_osc_mode != TSSM_MODE_INT;

    // Oscillator synchronisers; first stage read only by second
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ext_sync <= 2'h0;
            lf_sync  <= 2'h0;
            ext_prev <= 1'b0;
            lf_prev  <= 1'b0;
        end else begin
            ext_sync <= {ext_sync[0], ext_osc};
            lf_sync  <= {lf_sync[0], low_freq_internal_osc};
            ext_prev <= ext_sync[1];
            lf_prev  <= lf_sync[1];
        end
    end

    // Divide by 64: toggle every 32 low-frequency rising edges
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            div_cnt     <= 6'h0;
            sample_clk  <= 1'b0;
            sample_prev <= 1'b0;
        end else begin
            sample_prev <= sample_clk;
            if (lf_rise) begin
                div_cnt <= div_cnt + 6'h1;
                if (div_cnt[4:0] == TSSM_SAMPLE_DIV[4:0]) begin
                    sample_clk <= ~sample_clk;
                end
            end
        end
    end

    // Detector latch; set wins over clear so no edge is lost
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            det_latch <= 1'b0;
        end else if (ext_fall) begin
            det_latch <= 1'b1;
        end else if (sample_rise) begin
            det_latch <= 1'b0;
        end
    end

    // Sample latch state at each sample clock rising edge before clearing
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            det_sync1 <= 1'b1;
            det_sync2 <= 1'b1;
        end else begin
            // Re-armed outside run so a stale miss cannot refire after restart
            if (state != TSSM_ST_RUN) begin
                det_sync1 <= 1'b1;
            end else if (sample_rise) begin
                det_sync1 <= det_latch | ext_fall;
            end
            det_sync2 <= det_sync1;
        end
    end

    // Start-up sequencer
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state                  <= TSSM_ST_WAIT_POWERUP_TIMER;
            ost_cnt                <= 11'h0;
            startup_timeout_status <= 1'b0;
        end else begin
            case (state)
                TSSM_ST_WAIT_POWERUP_TIMER: begin
                    ost_cnt <= 11'h0;
                    if (powerup_timer_done) begin
                        state <= TSSM_ST_COUNT;
                    end
                end
                TSSM_ST_COUNT: begin
                    if (sleep_exec) begin
                        state <= TSSM_ST_SLEEP;
                    end else if (!is_crystal) begin
                        state <= TSSM_ST_RUN;
                    end else if (ost_cnt == TSSM_OST_COUNT) begin
                        state <= TSSM_ST_INT_FALL;
                    end else if (ext_fall) begin
                        ost_cnt <= ost_cnt + 11'h1;
                    end
                end
                TSSM_ST_INT_FALL: begin
                    if (sleep_exec) begin
                        state <= TSSM_ST_SLEEP;
                    end else if (int_fall || !two_speed_on) begin
                        startup_timeout_status <= 1'b1;
                        state                  <= TSSM_ST_HOLD;
                    end
                end
                TSSM_ST_HOLD: begin
                    if (ext_fall) begin
                        state <= TSSM_ST_RUN;
                    end
                end
                TSSM_ST_RUN: begin
                    if (sleep_exec) begin
                        state                  <= TSSM_ST_SLEEP;
                        startup_timeout_status <= 1'b0;
                    end else if (scs_changed) begin
                        state   <= TSSM_ST_COUNT;
                        ost_cnt <= 11'h0;
                        startup_timeout_status <= 1'b0;
                    end
                end
                TSSM_ST_SLEEP: begin
                    ost_cnt                <= 11'h0;
                    startup_timeout_status <= 1'b0;
                    if (wake_up) begin
                        state <= TSSM_ST_COUNT;
                    end
                end
                default: begin
                    state <= TSSM_ST_WAIT_POWERUP_TIMER;
                end
            endcase
        end
    end

    // Fail-safe condition
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            failed   <= 1'b0;
            scs_prev <= TSSM_SCS_PRIMARY;
        end else begin
            scs_prev <= clock_source_select;
            if (sleep_exec || scs_changed) begin
                failed <= 1'b0;
            end else if (monitored && state == TSSM_ST_RUN && !det_sync2) begin
                failed <= 1'b1;
            end
        end
    end

    // Fail flag: set wins over clear; clear refused while condition holds
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            osc_fail_flag <= 1'b0;
        end else if (monitored && state == TSSM_ST_RUN && !det_sync2) begin
            osc_fail_flag <= 1'b1;
        end else if (osc_fail_flag_clear && !failed) begin
            osc_fail_flag <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            timer_osc_ready_flag <= 1'b0;
        end else begin
            timer_osc_ready_flag <= timer_osc_enable & timer_osc_stable;
        end
    end

    // Multiplexer select registered so it never glitches
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            clock_mux_select  <= TSSM_SRC_INTERNAL;
            internal_freq_out <= TSSM_INTERNAL_FREQ_SELECT_RESET;
            clock_hold_low    <= 1'b0;
        end else begin
            internal_freq_out <= internal_freq_select;
            clock_hold_low    <= state == TSSM_ST_HOLD;
            if (clock_source_select[TSSM_SCS_INT_BIT] || failed) begin
                clock_mux_select <= TSSM_SRC_INTERNAL;
            end else if (clock_source_select == TSSM_SCS_TIMER_OSC) begin
                clock_mux_select <= TSSM_SRC_TIMER_OSC;
            end else if (state == TSSM_ST_RUN) begin
                clock_mux_select <= TSSM_SRC_PRIMARY;
            end else if (state == TSSM_ST_HOLD) begin
                clock_mux_select <= TSSM_SRC_HOLD;
            end else begin
                clock_mux_select <= TSSM_SRC_INTERNAL;
            end
        end
    end

    assign fail_safe_active = failed;
    assign osc_fail_irq     = osc_fail_flag & osc_fail_irq_enable;
endmodule

// ==== tb/tssm_osc_model.sv ====
// External crystal or clock source feeding the monitor's oscillator pin.
// Assumes the bench sets run and slow; a stopped source holds its level.
`timescale 1ns/1ps
module tssm_osc_model #(
    parameter int HALF_NS = 22
) (
    input  wire logic run,
    input  wire logic slow,
    output logic      osc
);
    initial begin
        osc = 1'h0;
        forever begin
            // Slow source still well inside one sample half period
            #(slow ? 3 * HALF_NS : HALF_NS);
            if (run) begin
                osc = ~osc;
            end
        end
    end
endmodule

// ==== tb/tssm_monitor_checker.sv ====
// Port checker for the start-up sequencer and fail-safe monitor.
// Assumes it is bound into tssm_monitor and sees its ports only.
`timescale 1ns/1ps
module tssm_monitor_checker
    import tssm_pkg::*;
(
    input wire logic       sys_clk, rst, sleep_exec, fail_monitor_enable,
    input wire logic       timer_osc_enable, timer_osc_stable, osc_fail_irq_enable,
    input wire logic       clock_hold_low, startup_timeout_status, timer_osc_ready_flag,
    input wire logic       osc_fail_flag, fail_safe_active, osc_fail_irq,
    input wire logic [1:0] clock_source_select,
    input wire logic [3:0] internal_freq_select, internal_freq_out,
    input wire tssm_mode_t primary_osc_mode,
    input wire tssm_src_t  clock_mux_select
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire xtal = primary_osc_mode inside {TSSM_MODE_LP, TSSM_MODE_XT, TSSM_MODE_HS};
    sequence s_ost_done;
        $rose(startup_timeout_status) && xtal && clock_source_select == TSSM_SCS_PRIMARY;
    endsequence
    sequence s_released;
        $fell(clock_hold_low) && startup_timeout_status;
    endsequence
    irq_gate_a: assert property (osc_fail_irq == (osc_fail_flag && osc_fail_irq_enable))
        else $error("interrupt differs from flag and enable");
    ready_delay_a: assert property (!$past(rst) |->
        timer_osc_ready_flag == $past(timer_osc_enable && timer_osc_stable))
        else $error("ready flag not one cycle behind its inputs");
    freq_pass_a: assert property (!$past(rst) |->
        internal_freq_out == $past(internal_freq_select))
        else $error("fallback frequency not passed on");
    fail_internal_a: assert property (fail_safe_active && $past(fail_safe_active) &&
        clock_source_select == TSSM_SCS_PRIMARY && $stable(clock_source_select)
        |-> clock_mux_select == TSSM_SRC_INTERNAL)
        else $error("clock left internal during failover");
    fail_flag_a: assert property ($rose(fail_safe_active) |-> ##[0:2] osc_fail_flag)
        else $error("fail flag not set on failure");
    clear_refused_a: assert property (fail_safe_active && osc_fail_flag |=> osc_fail_flag)
        else $error("fail flag cleared while failover active");
    sleep_abort_a: assert property (sleep_exec && !startup_timeout_status
        |=> !startup_timeout_status)
        else $error("status set after sleep");
    enable_gate_a: assert property ($rose(fail_safe_active) |-> fail_monitor_enable)
        else $error("failover without monitor enable");
    after_ost_a: assert property ($rose(fail_safe_active) && xtal
        |-> $past(startup_timeout_status))
        else $error("failure detected during start-up");
    hold_low_a: assert property (s_ost_done |-> ##[0:1] clock_hold_low)
        else $error("clock not held low at switchover");
    switch_a: assert property (s_released ##0 clock_source_select == TSSM_SCS_PRIMARY
        |-> ##[0:1] clock_mux_select == TSSM_SRC_PRIMARY)
        else $error("no switch to primary after hold");
endmodule
bind tssm_monitor tssm_monitor_checker chk_u (
    .sys_clk, .rst, .sleep_exec, .fail_monitor_enable, .timer_osc_enable, .timer_osc_stable,
    .osc_fail_irq_enable, .clock_hold_low, .startup_timeout_status, .timer_osc_ready_flag,
    .osc_fail_flag, .fail_safe_active, .osc_fail_irq, .clock_source_select,
    .internal_freq_select, .internal_freq_out, .primary_osc_mode, .clock_mux_select
);

// ==== tb/tb.sv ====
// Self-checking bench for the start-up sequencer and fail-safe monitor.
// Assumes the oscillator model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module tb;
    import tssm_pkg::*;
    logic       sys_clk, low_freq_internal_osc, ext_osc;
    logic       rst = 1'h1, run = 1'h1, slow = 1'h0, powerup_timer_done = 1'h1;
    logic       two_speed_enable = 1'h0, fail_monitor_enable = 1'h1;
    logic       timer_osc_enable = 1'h0, timer_osc_stable = 1'h0, osc_fail_irq_enable = 1'h1;
    logic [2:0] pls = 3'h0;
    logic [1:0] clock_source_select = 2'h0;
    logic [3:0] internal_freq_select = 4'h9, internal_freq_out;
    tssm_mode_t primary_osc_mode = TSSM_MODE_XT;
    tssm_src_t  clock_mux_select;
    logic       clock_hold_low, startup_timeout_status, timer_osc_ready_flag;
    logic       osc_fail_flag, fail_safe_active, osc_fail_irq;
    int         fails = 0, checked = 0, seed = 50, falls = 0, goal = 0;
    tssm_osc_model osc_u (.run(run), .slow(slow), .osc(ext_osc));
    tssm_monitor dut_u (
        .sys_clk, .rst, .ext_osc, .low_freq_internal_osc, .primary_osc_mode, .two_speed_enable,
        .fail_monitor_enable, .powerup_timer_done, .clock_source_select, .internal_freq_select,
        .sleep_exec(pls[0]), .wake_up(pls[1]), .timer_osc_enable, .timer_osc_stable,
        .osc_fail_flag_clear(pls[2]), .osc_fail_irq_enable, .clock_mux_select,
        .internal_freq_out, .clock_hold_low, .startup_timeout_status, .timer_osc_ready_flag,
        .osc_fail_flag, .fail_safe_active, .osc_fail_irq
    );
    initial begin
        sys_clk = 1'h0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    initial begin
        low_freq_internal_osc = 1'h0;
        forever #23 low_freq_internal_osc = ~low_freq_internal_osc;
    end
    always @(negedge ext_osc) falls++;
    task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic test_done;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    function automatic logic met(input int c);
        case (c)
            0: return startup_timeout_status === 1'h1;
            1: return fail_safe_active === 1'h1;
            2: return clock_mux_select === TSSM_SRC_PRIMARY;
            default: return falls >= goal;
        endcase
    endfunction
    // Bounded wait; a hang ends the run as a mismatch
    task automatic wait_on(input int c, input int lim);
        int k;
        k = 0;
        while (!met(c)) begin
            @(negedge sys_clk);
            k++;
            if (k > lim) begin
                fails++;
                $display("BAD wait %0d exp done got timeout", c);
                test_done();
            end
        end
    endtask
    task automatic pulse(input logic [2:0] m);
        pls = m;
        @(negedge sys_clk);
        pls = 3'h0;
    endtask
    task automatic restart(input int n);
        rst = 1'h1;
        repeat (3) @(negedge sys_clk);
        rst = 1'h0;
        falls = 0;
        repeat (n) @(negedge sys_clk);
    endtask
    initial begin
        restart(20);
        chk("mux two-speed", 4'(TSSM_SRC_INTERNAL), 4'(clock_mux_select));
        goal = 1000;
        wait_on(3, 12000);
        chk("status early", 4'h0, {3'h0, startup_timeout_status});
        wait_on(0, 3000);
        chk("full count", 4'h1, {3'h0, falls >= 1024});
        wait_on(2, 200);
        chk("fallback freq", internal_freq_select, internal_freq_out);
        run = 1'h0;
        wait_on(1, 2000);
        chk("fail flag", 4'h1, {3'h0, osc_fail_flag});
        @(negedge sys_clk);
        chk("mux failover", 4'(TSSM_SRC_INTERNAL), 4'(clock_mux_select));
        chk("irq", 4'h1, {3'h0, osc_fail_irq});
        osc_fail_irq_enable = 1'h0;
        @(negedge sys_clk);
        chk("irq masked", 4'h0, {3'h0, osc_fail_irq});
        pulse(3'h4);
        chk("clear refused", 4'h1, {3'h0, osc_fail_flag});
        pulse(3'h1);
        chk("sleep clears", 4'h0, {3'h0, fail_safe_active});
        pulse(3'h4);
        chk("flag cleared", 4'h0, {3'h0, osc_fail_flag});
        run = 1'h1;
        pulse(3'h2);
        goal = falls + 300;
        wait_on(3, 4000);
        pulse(3'h1);
        goal = falls + 1100;
        wait_on(3, 12000);
        chk("aborted status", 4'h0, {3'h0, startup_timeout_status});
        pulse(3'h2);
        wait_on(0, 12000);
        for (int i = 0; i < 16; i++) begin
            {timer_osc_enable, timer_osc_stable, internal_freq_select} = 6'($random(seed));
            @(negedge sys_clk);
            chk("ready", {3'h0, timer_osc_enable & timer_osc_stable}, {3'h0, timer_osc_ready_flag});
            chk("freq", internal_freq_select, internal_freq_out);
        end
        {timer_osc_enable, timer_osc_stable} = 2'h3;
        @(negedge sys_clk);
        if (timer_osc_ready_flag === 1'h1) clock_source_select = TSSM_SCS_TIMER_OSC;
        repeat (3) @(negedge sys_clk);
        chk("mux timer", 4'(TSSM_SRC_TIMER_OSC), 4'(clock_mux_select));
        clock_source_select = 2'h3;
        repeat (3) @(negedge sys_clk);
        chk("mux internal", 4'(TSSM_SRC_INTERNAL), 4'(clock_mux_select));
        clock_source_select = 2'h0;
        repeat (2) @(negedge sys_clk);
        chk("restart status", 4'h0, {3'h0, startup_timeout_status});
        wait_on(0, 12000);
        primary_osc_mode = TSSM_MODE_EC;
        two_speed_enable = 1'h1;
        slow = 1'h1;
        restart(20);
        chk("mux ext clock", 4'(TSSM_SRC_PRIMARY), 4'(clock_mux_select));
        repeat (600) @(negedge sys_clk);
        chk("slow ok", 4'h0, {3'h0, fail_safe_active});
        run = 1'h0;
        wait_on(1, 2000);
        clock_source_select = 2'h2;
        repeat (2) @(negedge sys_clk);
        chk("select clears", 4'h0, {3'h0, fail_safe_active});
        test_done();
    end
endmodule
